// ==== src/hv_indirect_config_data.sv ====
// Staging register, command interpreter and indirect configuration register.
// Assumes a word-wide MMR strobe port on the core clock; supply and short inputs are async.
//
// Behaviour
// - Staging register is twelve bits wide
// - Staging bits 11:8 report associated command
// - Codes: 0 read cfg, 2 read status, 8 write
// - Staging bits 7:0 hold transfer byte
// - Config register resets zero, command access only
// - Config bit 4 enables low supply flag
// - Config bit 3 enables attenuator diagnostic
// - Bit 2 re-enables driver, then self clears
// - Bit 1 set: report short, keep driver
// - Bit 1 clear: report short, disable driver
// - Short counted only after over 20 us
// - Config bit 0 enables LIN transceiver
// - Busy bit shows command in progress
// - Interrupt event while idle loads status into staging
`include "hv_indirect_params.svh"
`default_nettype none
module hv_indirect_config_data
   import hv_indirect_pkg::*;
#(
   parameter int SHORT_CYCLES   = (`HV_SHORT_MIN_NS * (`HV_CLOCK_HZ / 1000000)) / 1000 + 1,
   parameter int LATENCY_CYCLES = (`HV_LATENCY_MAX_NS * (`HV_CLOCK_HZ / 1000000)) / 1000
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [31:0] bus_addr,
   input  wire logic        bus_write,
   input  wire logic        bus_read,
   input  wire logic [31:0] bus_wdata,
   output logic      [31:0] bus_rdata,
   input  wire logic        lin_short_pin,
   input  wire logic        supply_low_pin,
   input  wire logic        irq_enable_mask,
   output logic             hv_irq,
   output logic             lin_driver_enable,
   output logic             lin_transceiver_enable,
   output logic             atten_diag_enable,
   output logic             low_supply_flag_enable
);
   hv_state_type state;
   logic [7:0]  hv_circuit_config;
   logic [7:0]  hv_status_indirect;
   logic [11:0] hv_data_staging;
   logic [3:0]  pending_cmd;
   logic [2:0]  cmd_flags;
   logic [15:0] wait_count;
   logic [15:0] short_count;
   logic        short_s1, short_s2, supply_s1, supply_s2;
   logic        short_seen, short_seen_d, low_supply_flag, driver_off;
   logic        wr_command, wr_staging, start_cmd, irq_load, done;

   function automatic logic valid_cmd(input logic [7:0] code);
      valid_cmd = (code == {4'h0, `HV_CMD_RD_CFG}) || (code == {4'h0, `HV_CMD_RD_STA})
                  || (code == {4'h0, `HV_CMD_WR_CFG});
   endfunction

   assign wr_command = bus_write && (bus_addr == `HV_COMMAND_ADDR);
   assign wr_staging = bus_write && (bus_addr == `HV_STAGING_ADDR);
   assign irq_load   = short_seen && !short_seen_d;
   assign start_cmd  = (state == idle_st) && wr_command && valid_cmd(bus_wdata[7:0]);
   assign done       = (state == busy_st) && (wait_count == 16'h0000);

   // Pins are asynchronous to the core clock
   always_ff @(posedge clock) begin
      if (rst) begin
         short_s1  <= 1'b0;
         short_s2  <= 1'b0;
         supply_s1 <= 1'b0;
         supply_s2 <= 1'b0;
      end else begin
         short_s1  <= lin_short_pin;
         short_s2  <= short_s1;
         supply_s1 <= supply_low_pin;
         supply_s2 <= supply_s1;
      end
   end

   // Short filter: glitches under the minimum never reach the status bit
   always_ff @(posedge clock) begin
      if (rst) begin
         short_count <= 16'h0000;
         short_seen  <= 1'b0;
      end else if (!short_s2) begin
         short_count <= 16'h0000;
         short_seen  <= 1'b0;
      end else if (short_count >= 16'(SHORT_CYCLES)) begin
         short_seen <= 1'b1;
      end else begin
         short_count <= short_count + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) short_seen_d <= 1'b0;
      else short_seen_d <= short_seen;
   end

   // Command sequencer; an interrupt load also occupies the interface
   always_ff @(posedge clock) begin
      if (rst) begin
         state       <= idle_st;
         pending_cmd <= `HV_CMD_RD_CFG;
         wait_count  <= 16'h0000;
         cmd_flags   <= 3'b000;
      end else begin
         case (state)
            idle_st: begin
               if (irq_load) begin
                  state       <= busy_st;
                  pending_cmd <= `HV_CMD_RD_STA;
                  wait_count  <= 16'(LATENCY_CYCLES - 1);
                  cmd_flags   <= 3'b001;
               end else if (start_cmd) begin
                  state       <= busy_st;
                  pending_cmd <= bus_wdata[3:0];
                  wait_count  <= 16'(LATENCY_CYCLES - 1);
                  cmd_flags   <= 3'b001;
               end
            end
            busy_st: begin
               if (done) begin
                  state     <= idle_st;
                  cmd_flags <= (pending_cmd == `HV_CMD_WR_CFG) ? 3'b100 : 3'b010;
               end else begin
                  wait_count <= wait_count - 16'h0001;
               end
            end
            default: state <= idle_st;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hv_data_staging <= 12'h000;
      end else if (done && pending_cmd != `HV_CMD_WR_CFG) begin
         hv_data_staging <= {pending_cmd,
            (pending_cmd == `HV_CMD_RD_STA) ? hv_status_indirect : hv_circuit_config};
      end else if (done) begin
         hv_data_staging[11:8] <= pending_cmd;
      end else if (wr_staging && state == idle_st) begin
         hv_data_staging[7:0] <= bus_wdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         hv_circuit_config <= `HV_CFG_RESET;
      end else if (done && pending_cmd == `HV_CMD_WR_CFG) begin
         hv_circuit_config <= hv_data_staging[7:0] & `HV_CFG_USED_MASK;
      end else begin
         hv_circuit_config[`HV_BIT_LIN_REEN] <= 1'b0;
      end
   end

   // Low-supply latch: armed by enabling, dropped by a supply dip or disabling
   // Enable bit only moves on a config write, so the write itself arms or drops
   always_ff @(posedge clock) begin
      if (rst) begin
         low_supply_flag <= 1'b0;
      end else if (supply_s2) begin
         low_supply_flag <= 1'b0;
      end else if (done && pending_cmd == `HV_CMD_WR_CFG) begin
         low_supply_flag <= hv_data_staging[`HV_BIT_LOWSUP_EN];
      end
   end

   // Short status: new event wins over the read clear
   always_ff @(posedge clock) begin
      if (rst) begin
         hv_status_indirect <= `HV_STA_RESET;
      end else begin
         hv_status_indirect[`HV_STA_BIT_LOWSUP] <= low_supply_flag;
         if (irq_load)
            hv_status_indirect[`HV_STA_BIT_SHORT] <= 1'b1;
         else if ((done && pending_cmd == `HV_CMD_RD_STA) || hv_circuit_config[`HV_BIT_LIN_REEN])
            hv_status_indirect[`HV_STA_BIT_SHORT] <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         driver_off <= 1'b0;
      end else if (irq_load && !hv_circuit_config[`HV_BIT_SC_PASSIVE]) begin
         driver_off <= 1'b1;
      end else if (hv_circuit_config[`HV_BIT_LIN_REEN]) begin
         driver_off <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) bus_rdata <= 32'h0000_0000;
      else if (bus_read && bus_addr == `HV_STAGING_ADDR) bus_rdata <= {20'h00000, hv_data_staging};
      else if (bus_read && bus_addr == `HV_COMMAND_ADDR) bus_rdata <= {29'h0, cmd_flags};
      else bus_rdata <= 32'h0000_0000;
   end

   assign hv_irq                 = hv_status_indirect[`HV_STA_BIT_SHORT] && irq_enable_mask;
   assign lin_transceiver_enable = hv_circuit_config[`HV_BIT_LIN_EN];
   assign lin_driver_enable      = hv_circuit_config[`HV_BIT_LIN_EN] && !driver_off;
   assign atten_diag_enable      = hv_circuit_config[`HV_BIT_ATTEN_DIAG];
   assign low_supply_flag_enable = hv_circuit_config[`HV_BIT_LOWSUP_EN];

   // Independent run length of the synchronised short; the filter check
   // must not lean on the filter's own counter
   logic [15:0] short_run;

   always_ff @(posedge clock) begin
      if (rst || !short_s2) begin
         short_run <= 16'h0000;
      end else if (short_run != 16'hFFFF) begin
         short_run <= short_run + 16'h0001;
      end
   end

   a_busy_length: assert property (@(posedge clock) disable iff (rst)
      $rose(state == busy_st) |-> (state == busy_st) [*8] ##[1:300] (state == idle_st))
      else $error("busy window wrong");

   a_busy_refuse: assert property (@(posedge clock) disable iff (rst)
      (state == busy_st && !done) |=> $stable(pending_cmd))
      else $error("command taken while busy");

   a_irq_loads_status: assert property (@(posedge clock) disable iff (rst)
      (irq_load && state == idle_st) |=> pending_cmd == `HV_CMD_RD_STA)
      else $error("interrupt did not queue status load");

   a_status_load: assert property (@(posedge clock) disable iff (rst)
      (done && pending_cmd == `HV_CMD_RD_STA) |=>
      hv_data_staging == {`HV_CMD_RD_STA, $past(hv_status_indirect)})
      else $error("status not loaded into staging");

   a_reenable_clears: assert property (@(posedge clock) disable iff (rst)
      hv_circuit_config[`HV_BIT_LIN_REEN] |=> !hv_circuit_config[`HV_BIT_LIN_REEN])
      else $error("re-enable bit stuck");

   a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
      hv_circuit_config[7:5] == 3'b000)
      else $error("reserved config bits set");

   a_active_off: assert property (@(posedge clock) disable iff (rst)
      (irq_load && !hv_circuit_config[`HV_BIT_SC_PASSIVE] && !hv_circuit_config[`HV_BIT_LIN_REEN])
      |=> !lin_driver_enable)
      else $error("driver kept on in active mode");

   a_passive_keep: assert property (@(posedge clock) disable iff (rst)
      (hv_circuit_config[`HV_BIT_SC_PASSIVE] && !driver_off) |=> !driver_off)
      else $error("driver cut in passive mode");

   a_short_status: assert property (@(posedge clock) disable iff (rst)
      irq_load |=> hv_status_indirect[`HV_STA_BIT_SHORT])
      else $error("short not recorded in status");

   a_short_filter: assert property (@(posedge clock) disable iff (rst)
      $rose(short_seen) |-> short_run > 16'(SHORT_CYCLES))
      else $error("short accepted too early");

   a_cmd_field_hold: assert property (@(posedge clock) disable iff (rst)
      !done |=> $stable(hv_data_staging[11:8]))
      else $error("command field changed without completion");

   a_write_config: assert property (@(posedge clock) disable iff (rst)
      (done && pending_cmd == `HV_CMD_WR_CFG) |=>
      hv_circuit_config == ($past(hv_data_staging[7:0]) & `HV_CFG_USED_MASK))
      else $error("config write lost");

   a_lowsup_drop: assert property (@(posedge clock) disable iff (rst)
      supply_s2 |=> !low_supply_flag)
      else $error("low supply flag survived a dip");

   // Main scenarios worth seeing at least once
   c_write_cmd: cover property (@(posedge clock) done && pending_cmd == `HV_CMD_WR_CFG);
   c_read_sta: cover property (@(posedge clock) done && pending_cmd == `HV_CMD_RD_STA);
   c_short_off: cover property (@(posedge clock) irq_load && driver_off == 1'b0);
   c_short_glitch: cover property (@(posedge clock) $fell(short_s2) && !short_seen);
   c_lowsup_drop: cover property (@(posedge clock) $fell(low_supply_flag));
endmodule
`default_nettype wire

// ==== src/hv_indirect_params.svh ====
// Constants for the indirect high-voltage configuration block.
// Included by the bench and the design module; definitions only.
`ifndef HV_INDIRECT_PARAMS_SVH
`define HV_INDIRECT_PARAMS_SVH
`define HV_STAGING_ADDR   32'hFFFF080C
`define HV_COMMAND_ADDR   32'hFFFF0804
`define HV_CMD_RD_CFG     4'h0
`define HV_CMD_RD_STA     4'h2
`define HV_CMD_WR_CFG     4'h8
`define HV_CFG_RESET      8'h00
`define HV_STA_RESET      8'h00
`define HV_CFG_USED_MASK  8'h1F
`define HV_BIT_LOWSUP_EN  4
`define HV_BIT_ATTEN_DIAG 3
`define HV_BIT_LIN_REEN   2
`define HV_BIT_SC_PASSIVE 1
`define HV_BIT_LIN_EN     0
`define HV_STA_BIT_SHORT  0
`define HV_STA_BIT_LOWSUP 2
`define HV_CMD_BIT_BUSY   0
`define HV_CMD_BIT_RD_OK  1
`define HV_CMD_BIT_WR_OK  2
`define HV_CLOCK_HZ       20000000
`define HV_SHORT_MIN_NS   20000
`define HV_LATENCY_MAX_NS 10000
`endif

// ==== src/hv_indirect_pkg.sv ====
// Types shared by the indirect high-voltage configuration block.
// Assumes the params header is on the include path.
`default_nettype none
package hv_indirect_pkg;
   typedef enum logic [1:0] {idle_st, busy_st} hv_state_type;
endpackage
`default_nettype wire

// ==== sim/hv_far_side.sv ====
// Far side model: LIN pin short detector and digital supply monitor.
// Assumes the bench calls short_event just after a rising clock edge.
`default_nettype none
module hv_far_side (
   input  wire logic clock,
   output logic      lin_short_pin,
   output logic      supply_low_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      lin_short_pin  = 1'b0;
      supply_low_pin = 1'b0;
   end
   // Short held n cycles; the bench picks n either side of the threshold
   task automatic short_event(input int n);
      lin_short_pin = 1'b1;
      repeat (n) @(posedge clock);
      #2 lin_short_pin = 1'b0;
   endtask
   // Supply dip held n cycles
   task automatic supply_dip(input int n);
      supply_low_pin = 1'b1;
      repeat (n) @(posedge clock);
      #2 supply_low_pin = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== sim/hv_indirect_config_data_tb.sv ====
// Bench for the indirect configuration block: bus tasks, sequenced checks.
// Assumes the far side model drives the short and supply pins.
`include "hv_indirect_params.svh"
`default_nettype none
module hv_indirect_config_data_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int          SC  = 20;
   localparam logic [31:0] STG = `HV_STAGING_ADDR;
   localparam logic [31:0] CMD = `HV_COMMAND_ADDR;
   logic        clock, rst, bus_write, bus_read, irq_enable_mask;
   logic        hv_irq, lin_driver_enable, lin_transceiver_enable;
   logic        atten_diag_enable, low_supply_flag_enable, lin_short_pin, supply_low_pin;
   logic [31:0] bus_addr, bus_wdata, bus_rdata;
   int          bad_count, check_count, cycles;

   hv_far_side u_far (.clock(clock), .lin_short_pin(lin_short_pin),
      .supply_low_pin(supply_low_pin));
   hv_indirect_config_data #(.SHORT_CYCLES(SC), .LATENCY_CYCLES(10)) u_dut (
      .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_write(bus_write),
      .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .lin_short_pin(lin_short_pin), .supply_low_pin(supply_low_pin),
      .irq_enable_mask(irq_enable_mask), .hv_irq(hv_irq),
      .lin_driver_enable(lin_driver_enable), .lin_transceiver_enable(lin_transceiver_enable),
      .atten_diag_enable(atten_diag_enable), .low_supply_flag_enable(low_supply_flag_enable));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard: whole run needs well under two thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Idle cycle after each strobe so no strobe is lowered and raised at once
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus_addr  = a;
      bus_wdata = d;
      bus_write = 1'b1;
      @(posedge clock);
      #2 bus_write = 1'b0;
      @(posedge clock);
      #2;
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      bus_addr = a;
      bus_read = 1'b1;
      @(posedge clock);
      #2 bus_read = 1'b0;
      d = bus_rdata;
      @(posedge clock);
      #2;
   endtask

   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   task automatic wait_idle();
      logic [31:0] d;
      d = 32'h1;
      for (int i = 0; i < 50 && d[0] !== 1'b0; i++)
         rd(CMD, d);
      chk({31'h0, d[0]}, 32'h0);
   endtask

   task automatic cmd(input logic [7:0] c);
      wr(CMD, {24'h0, c});
      wait_idle();
   endtask

   initial begin
      rst = 1'b1;
      bus_write = 1'b0;
      bus_read = 1'b0;
      bus_addr = 32'h0;
      bus_wdata = 32'h0;
      irq_enable_mask = 1'b0;
      repeat (6) @(posedge clock);
      #2 rst = 1'b0;
      chk({hv_irq, lin_driver_enable, lin_transceiver_enable, atten_diag_enable}, 0);
      cmd(8'h00);
      rchk(STG, 32'h000);
      $display("test reset done");
      wr(STG, 32'hFFF);
      rchk(STG, 32'h0FF);
      wr(CMD, 32'h08);
      rchk(CMD, 32'h01);
      wr(CMD, 32'h00);
      wait_idle();
      rchk(CMD, 32'h04);
      rchk(STG, 32'h8FF);
      chk({lin_transceiver_enable, atten_diag_enable, low_supply_flag_enable}, 7);
      cmd(8'h00);
      rchk(STG, 32'h01B);
      wr(CMD, 32'h05);
      rchk(CMD, 32'h02);
      $display("test command path done");
      wr(STG, 32'h01);
      cmd(8'h08);
      chk({low_supply_flag_enable, atten_diag_enable}, 0);
      irq_enable_mask = 1'b1;
      u_far.short_event(SC - 4);
      repeat (6) @(posedge clock);
      #2 chk({hv_irq, lin_driver_enable}, 2'b01);
      u_far.short_event(SC + 8);
      repeat (4) @(posedge clock);
      #2 chk({hv_irq, lin_driver_enable}, 2'b10);
      wait_idle();
      rchk(STG, 32'h201);
      wr(STG, 32'h05);
      cmd(8'h08);
      chk({hv_irq, lin_driver_enable}, 2'b01);
      $display("test active protection done");
      wr(STG, 32'h03);
      cmd(8'h08);
      u_far.short_event(SC + 8);
      repeat (4) @(posedge clock);
      #2 chk({hv_irq, lin_driver_enable}, 2'b11);
      wait_idle();
      irq_enable_mask = 1'b0;
      #1 chk({31'h0, hv_irq}, 0);
      cmd(8'h02);
      rchk(STG, 32'h200);
      irq_enable_mask = 1'b1;
      #1 chk({31'h0, hv_irq}, 0);
      $display("test passive protection done");
      wr(STG, 32'h11);
      cmd(8'h08);
      cmd(8'h02);
      rchk(STG, 32'h204);
      u_far.supply_dip(3);
      cmd(8'h02);
      rchk(STG, 32'h200);
      $display("test low supply done");
      end_sim();
   end
endmodule
`default_nettype wire
